// *** verilog/dfc_filter.sv ***
// Purpose: Stereo symmetric five-tap FIR compensation filter with its register set
// Assumes: Registers written one byte at a time from the serial control port
// Notes: Samples pass through an 8-deep FIFO before the filter stage
//
// What this block does
// - Taps one and five share the coefficient held at 0x10 (low) and 0x11 (high).
// - Taps two and four share the coefficient held at 0x12 (low) and 0x13 (high).
// - The centre tap takes its coefficient from 0x14 (low) and 0x15 (high).
// - Each coefficient is 16 bits, low byte in bits 7:0 and high byte in bits 15:8.
// - With custom response off in setup register 0x0E the built-in linear defaults apply.
// - Selection 00 without custom response uses 434, -2291 and 26984.
// - Selections 01, 10 and 11 without custom response use 61, -371 and 25699.
// - Coefficients are two's-complement signed values on both sides.
// - Setup bit 6 switches the filter to the programmed coefficients.
// - Setup bits 1:0 select 125x, 128x, 64x or 32x oversampling for 00 to 11.
`timescale 1ns/1ps
`default_nettype none
`include "dfc_map.svh"
module dfc_filter (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Control port register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire dfc_pkg::dfc_byte_t reg_addr,
   input wire dfc_pkg::dfc_byte_t reg_wdata,
   output dfc_pkg::dfc_byte_t reg_rdata,
   // Setup state
   output dfc_pkg::dfc_osr_e osr_mode,
   output logic custom_response_enable,
   // Sample input
   input wire logic in_valid,
   output logic in_ready,
   input wire dfc_pkg::dfc_sample_t in_left,
   input wire dfc_pkg::dfc_sample_t in_right,
   // Filtered output
   output logic out_valid,
   input wire logic out_ready,
   output dfc_pkg::dfc_sample_t out_left,
   output dfc_pkg::dfc_sample_t out_right
);
   import dfc_pkg::*;

   dfc_byte_t setup_reg;
   dfc_byte_t outer_tap_coeff_low_reg;
   dfc_byte_t outer_tap_coeff_high_reg;
   dfc_byte_t inner_tap_coeff_low_reg;
   dfc_byte_t inner_tap_coeff_high_reg;
   dfc_byte_t centre_tap_coeff_low_reg;
   dfc_byte_t centre_tap_coeff_high_reg;
   dfc_byte_t rdata_next;
   dfc_osr_e osr_sel;
   dfc_coeff_t c_outer;
   dfc_coeff_t c_inner;
   dfc_coeff_t c_centre;
   logic f_valid;
   logic f_ready;
   logic [31:0] f_data;
   logic take;
   logic out_valid_reg;
   dfc_sample_t line_reg [`DFC_NUM_CH][4];
   dfc_sample_t y_reg [`DFC_NUM_CH];
   logic lines_match;

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         setup_reg <= `DFC_REG_RESET;
         outer_tap_coeff_low_reg <= `DFC_REG_RESET;
         outer_tap_coeff_high_reg <= `DFC_REG_RESET;
         inner_tap_coeff_low_reg <= `DFC_REG_RESET;
         inner_tap_coeff_high_reg <= `DFC_REG_RESET;
         centre_tap_coeff_low_reg <= `DFC_REG_RESET;
         centre_tap_coeff_high_reg <= `DFC_REG_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `DFC_ADDR_SETUP: setup_reg <= reg_wdata;
            `DFC_ADDR_OUTER_LO: outer_tap_coeff_low_reg <= reg_wdata;
            `DFC_ADDR_OUTER_HI: outer_tap_coeff_high_reg <= reg_wdata;
            `DFC_ADDR_INNER_LO: inner_tap_coeff_low_reg <= reg_wdata;
            `DFC_ADDR_INNER_HI: inner_tap_coeff_high_reg <= reg_wdata;
            `DFC_ADDR_CENTRE_LO: centre_tap_coeff_low_reg <= reg_wdata;
            `DFC_ADDR_CENTRE_HI: centre_tap_coeff_high_reg <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      case (reg_addr)
         `DFC_ADDR_SETUP: rdata_next = setup_reg;
         `DFC_ADDR_OUTER_LO: rdata_next = outer_tap_coeff_low_reg;
         `DFC_ADDR_OUTER_HI: rdata_next = outer_tap_coeff_high_reg;
         `DFC_ADDR_INNER_LO: rdata_next = inner_tap_coeff_low_reg;
         `DFC_ADDR_INNER_HI: rdata_next = inner_tap_coeff_high_reg;
         `DFC_ADDR_CENTRE_LO: rdata_next = centre_tap_coeff_low_reg;
         `DFC_ADDR_CENTRE_HI: rdata_next = centre_tap_coeff_high_reg;
         default: rdata_next = `DFC_READ_UNMAPPED;
      endcase
   end

   // Read data holds until the next read strobe
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= `DFC_REG_RESET;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         osr_mode <= DFC_OSR_125X;
         custom_response_enable <= 1'b0;
      end else begin
         osr_mode <= osr_sel;
         custom_response_enable <= setup_reg[`DFC_CUSTOM_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Active coefficient set

   assign osr_sel = dfc_osr_e'(setup_reg[`DFC_OSR_MSB:`DFC_OSR_LSB]);

   // Coefficient bytes are used live, so a half-written pair is briefly in effect
   always_comb begin
      if (setup_reg[`DFC_CUSTOM_BIT]) begin
         c_outer = {outer_tap_coeff_high_reg, outer_tap_coeff_low_reg};
         c_inner = {inner_tap_coeff_high_reg, inner_tap_coeff_low_reg};
         c_centre = {centre_tap_coeff_high_reg, centre_tap_coeff_low_reg};
      end else if (osr_sel == DFC_OSR_125X) begin
         c_outer = `DFC_DEF_A_OUTER;
         c_inner = `DFC_DEF_A_INNER;
         c_centre = `DFC_DEF_A_CENTRE;
      end else begin
         c_outer = `DFC_DEF_B_OUTER;
         c_inner = `DFC_DEF_B_INNER;
         c_centre = `DFC_DEF_B_CENTRE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input FIFO and filter stage

   dfc_fifo #(
      .WIDTH(32),
      .DEPTH(`DFC_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data({in_left, in_right}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // A stalled output stops the FIFO draining, so back-pressure reaches in_ready
   assign take = f_valid && (!out_valid_reg || out_ready);
   assign f_ready = take;
   assign out_valid = out_valid_reg;
   assign out_right = y_reg[0];
   assign out_left = y_reg[1];

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         out_valid_reg <= 1'b0;
      end else if (take) begin
         out_valid_reg <= 1'b1;
      end else if (out_ready) begin
         out_valid_reg <= 1'b0;
      end
   end

   for (genvar ch = 0; ch < `DFC_NUM_CH; ch++) begin : g_ch
      dfc_sample_t x_new;
      logic signed [16:0] pair_outer;
      logic signed [16:0] pair_inner;
      logic signed [34:0] acc;
      logic signed [34:0] scaled;
      dfc_sample_t y_next;

      assign x_new = f_data[ch*16 +: 16];
      // Symmetric taps are summed before the multiply to save two multipliers
      assign pair_outer = 17'(x_new) + 17'(line_reg[ch][3]);
      assign pair_inner = 17'(line_reg[ch][0]) + 17'(line_reg[ch][2]);
      // Signed products throughout: coefficients are two's complement
      assign acc = 35'(pair_outer * c_outer) + 35'(pair_inner * c_inner)
         + 35'(line_reg[ch][1] * c_centre);
      assign scaled = acc >>> `DFC_FRAC_BITS;

      always_comb begin
         if (scaled > 35'(signed'(`DFC_SAT_POS))) begin
            y_next = `DFC_SAT_POS;
         end else if (scaled < 35'(signed'(`DFC_SAT_NEG))) begin
            y_next = `DFC_SAT_NEG;
         end else begin
            y_next = scaled[15:0];
         end
      end

      always_ff @(posedge ref_clk or negedge resetn) begin
         if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
               line_reg[ch][i] <= '0;
            end
            y_reg[ch] <= '0;
         end else if (take) begin
            line_reg[ch][0] <= x_new;
            for (int i = 1; i < 4; i++) begin
               line_reg[ch][i] <= line_reg[ch][i-1];
            end
            y_reg[ch] <= y_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   assign lines_match = (line_reg[0][0] == line_reg[1][0]) && (line_reg[0][1] == line_reg[1][1])
      && (line_reg[0][2] == line_reg[1][2]) && (line_reg[0][3] == line_reg[1][3])
      && (f_data[15:0] == f_data[31:16]);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   a_outer_write_use: assert property (
      reg_wr && reg_addr == `DFC_ADDR_OUTER_LO ##1 setup_reg[`DFC_CUSTOM_BIT]
      |-> c_outer[7:0] == $past(reg_wdata))
      else $error("outer low byte not used");
   a_inner_pair: assert property (
      reg_wr && reg_addr == `DFC_ADDR_INNER_HI ##1 setup_reg[`DFC_CUSTOM_BIT]
      |-> c_inner[15:8] == $past(reg_wdata))
      else $error("inner high byte not used");
   a_centre_high_byte: assert property (
      reg_wr && reg_addr == `DFC_ADDR_CENTRE_HI ##1 setup_reg[`DFC_CUSTOM_BIT]
      |-> c_centre[15:8] == $past(reg_wdata))
      else $error("centre high byte not used");
   a_default_osr_a: assert property (
      !setup_reg[`DFC_CUSTOM_BIT] && setup_reg[`DFC_OSR_MSB:`DFC_OSR_LSB] == 2'h0
      |-> c_outer == 16'sd434 && c_inner == -16'sd2291 && c_centre == 16'sd26984)
      else $error("wrong default set for selection 00");
   a_default_osr_b: assert property (
      !setup_reg[`DFC_CUSTOM_BIT] && setup_reg[`DFC_OSR_MSB:`DFC_OSR_LSB] != 2'h0
      |-> c_outer == 16'sd61 && c_inner == -16'sd371 && c_centre == 16'sd25699)
      else $error("wrong default set for other selections");
   a_defaults_ignore_regs: assert property (
      !setup_reg[`DFC_CUSTOM_BIT] && $stable(setup_reg) |-> $stable(c_outer) && $stable(c_centre))
      else $error("defaults moved with programmed registers");
   // Only the inner pair is non-zero here, so a negative default must give a negative result
   a_signed_inner: assert property (
      take && !setup_reg[`DFC_CUSTOM_BIT] && f_data[15:0] == 16'h0000 && line_reg[0][0] == 16'h0100
      && line_reg[0][1] == 16'h0000 && line_reg[0][2] == 16'h0000 && line_reg[0][3] == 16'h0000
      |=> out_right < 16'sd0)
      else $error("coefficient sign lost");
   a_custom_bit: assert property (
      reg_wr && reg_addr == `DFC_ADDR_SETUP
      |-> ##2 custom_response_enable == $past(reg_wdata[`DFC_CUSTOM_BIT], 2))
      else $error("custom enable not following setup bit");
   a_osr_decode: assert property (
      reg_wr && reg_addr == `DFC_ADDR_SETUP && reg_wdata[1:0] == 2'h3 |-> ##2 osr_mode == DFC_OSR_32X)
      else $error("oversampling selection decode wrong");
   a_stereo_same: assert property (
      take && lines_match |=> out_left == out_right)
      else $error("equal channels filtered differently");

   c_custom_sample: cover property (take && setup_reg[`DFC_CUSTOM_BIT]);
   c_default_sample: cover property (take && !setup_reg[`DFC_CUSTOM_BIT]);
   c_fifo_full: cover property (!in_ready && in_valid);
   c_out_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
endmodule
`default_nettype wire

// *** verilog/dfc_map.svh ***
// Purpose: Addresses, field positions, reset values and default coefficients
// Assumes: Byte-wide registers on the serial control port
// Notes: Definitions only
`ifndef DFC_MAP_SVH
`define DFC_MAP_SVH

`define DFC_ADDR_SETUP 8'h0E
`define DFC_ADDR_OUTER_LO 8'h10
`define DFC_ADDR_OUTER_HI 8'h11
`define DFC_ADDR_INNER_LO 8'h12
`define DFC_ADDR_INNER_HI 8'h13
`define DFC_ADDR_CENTRE_LO 8'h14
`define DFC_ADDR_CENTRE_HI 8'h15

`define DFC_OSR_MSB 1
`define DFC_OSR_LSB 0
`define DFC_CUSTOM_BIT 6
`define DFC_REG_RESET 8'h00
`define DFC_READ_UNMAPPED 8'h00

// Defaults for oversampling selection 00: 434, -2291, 26984
`define DFC_DEF_A_OUTER 16'h01B2
`define DFC_DEF_A_INNER 16'hF70D
`define DFC_DEF_A_CENTRE 16'h6968
// Defaults for the other selections: 61, -371, 25699
`define DFC_DEF_B_OUTER 16'h003D
`define DFC_DEF_B_INNER 16'hFE8D
`define DFC_DEF_B_CENTRE 16'h6463

`define DFC_FRAC_BITS 15
`define DFC_SAT_POS 16'h7FFF
`define DFC_SAT_NEG 16'h8000
`define DFC_FIFO_DEPTH 8
`define DFC_NUM_CH 2

`endif

// *** verilog/dfc_pkg.sv ***
// Purpose: Types shared by the compensation filter files
// Assumes: 16-bit samples and coefficients
// Notes: Oversampling enum order follows the two-bit selection encoding
package dfc_pkg;
   typedef enum logic [1:0] {DFC_OSR_125X, DFC_OSR_128X, DFC_OSR_64X, DFC_OSR_32X} dfc_osr_e;
   typedef logic signed [15:0] dfc_coeff_t;
   typedef logic signed [15:0] dfc_sample_t;
   typedef logic [7:0] dfc_byte_t;
endpackage

// *** verilog/dfc_fifo.sv ***
// Purpose: Sample FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: in_ready is registered so the filter's input ready comes from a flop
`timescale 1ns/1ps
`default_nettype none
module dfc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rptr_reg];

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wptr_reg] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= rptr_reg + 1'b1;
         end
         count_reg <= count_next;
         in_ready <= (count_next != (AW+1)'(DEPTH));
      end
   end
endmodule
`default_nettype wire

// *** verif/tb_dfc_filter.sv ***
// Purpose: Self-checking bench for the stereo compensation filter
// Assumes: Byte strobe register port, sample FIFO of 8 pairs
// Notes: Expected outputs come from a reference model of the FIR kept here
`timescale 1ns/1ps
`default_nettype none
module tb_dfc_filter;
   import dfc_pkg::*;
   logic ref_clk, resetn, reg_wr, reg_rd, in_valid, out_ready;
   dfc_byte_t reg_addr, reg_wdata, reg_rdata;
   dfc_osr_e osr_mode;
   logic custom_response_enable, in_ready, out_valid;
   dfc_sample_t in_left, in_right, out_left, out_right;
   int n_mismatch = 0;
   int cmp_count = 0;
   longint c0, c1, c2;
   longint hl[5], hr[5];
   logic [31:0] exp_q[$];

   dfc_filter u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osr_mode(osr_mode),
      .custom_response_enable(custom_response_enable), .in_valid(in_valid),
      .in_ready(in_ready), .in_left(in_left), .in_right(in_right), .out_valid(out_valid),
      .out_ready(out_ready), .out_left(out_left), .out_right(out_right));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_write(input dfc_byte_t a, input dfc_byte_t d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk);
      #1 reg_wr = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic reg_read(input dfc_byte_t a, output dfc_byte_t d);
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge ref_clk);
      #1 reg_rd = 1'b0;
      @(posedge ref_clk);
      #1 d = reg_rdata;
   endtask

   task automatic setup(input dfc_byte_t d);
      reg_write(`DFC_ADDR_SETUP, d);
      repeat (2) @(posedge ref_clk);
      #1 chk({14'h0000, osr_mode}, {14'h0000, d[1:0]});
      chk({15'h0000, custom_response_enable}, {15'h0000, d[6]});
   endtask

   // Reference FIR: floor shift of the Q15 sum, then saturation to 16 bits
   function automatic logic [15:0] fir(input longint h[5]);
      longint acc;
      acc = (c0 * (h[0] + h[4]) + c1 * (h[1] + h[3]) + c2 * h[2]) >>> 15;
      if (acc > 32767) acc = 32767;
      if (acc < -32768) acc = -32768;
      return acc[15:0];
   endfunction

   task automatic model_push(input logic [15:0] l, input logic [15:0] r);
      for (int i = 4; i > 0; i--) begin
         hl[i] = hl[i-1];
         hr[i] = hr[i-1];
      end
      hl[0] = longint'($signed(l));
      hr[0] = longint'($signed(r));
      exp_q.push_back({fir(hl), fir(hr)});
   endtask

   task automatic send(input logic [15:0] l, input logic [15:0] r);
      int i;
      in_valid = 1'b1;
      in_left = l;
      in_right = r;
      for (i = 0; i < 50 && in_ready !== 1'b1; i++) @(posedge ref_clk) #1;
      if (i == 50) begin
         n_mismatch++;
         complete_run();
      end
      model_push(l, r);
      @(posedge ref_clk);
      #1;
   endtask

   task automatic recv_all();
      int i;
      logic [31:0] e;
      out_ready = 1'b1;
      while (exp_q.size() > 0) begin
         for (i = 0; i < 50 && out_valid !== 1'b1; i++) @(posedge ref_clk) #1;
         if (i == 50) begin
            n_mismatch++;
            complete_run();
         end
         e = exp_q.pop_front();
         chk(out_left, e[31:16]);
         chk(out_right, e[15:0]);
         @(posedge ref_clk);
         #1;
      end
      out_ready = 1'b0;
   endtask

   // Impulse of amplitude a, then a short ramp; right carries the inverse
   task automatic run_block(input int n, input logic [15:0] a);
      logic [15:0] l;
      for (int k = 0; k < n; k++) begin
         l = (k == 0) ? a : 16'(k << 10);
         send(l, ~l);
      end
      in_valid = 1'b0;
      recv_all();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      dfc_byte_t d;
      dfc_byte_t addrs[7] = '{8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
      foreach (addrs[i]) begin
         reg_read(addrs[i], d);
         chk({8'h00, d}, 16'h0000);
      end
      chk({14'h0000, osr_mode}, {14'h0000, DFC_OSR_125X});
      chk({15'h0000, in_ready}, 16'h0001);
      $display("test reset done");
   endtask

   task automatic t_regs();
      dfc_byte_t d;
      dfc_byte_t vals[6] = '{8'h38, 8'hFF, 8'h34, 8'h12, 8'h40, 8'hA2};
      foreach (vals[i]) reg_write(8'(8'h10 + i), vals[i]);
      reg_write(8'h16, 8'hA5);
      reg_write(8'h0D, 8'h5A);
      foreach (vals[i]) begin
         reg_read(8'(8'h10 + i), d);
         chk({8'h00, d}, {8'h00, vals[i]});
      end
      reg_read(8'h16, d);
      chk({8'h00, d}, 16'h0000);
      reg_read(8'h0D, d);
      chk({8'h00, d}, 16'h0000);
      $display("test registers done");
   endtask

   task automatic t_defaults();
      for (int m = 0; m < 4; m++) begin
         setup(8'(m));
         c0 = (m == 0) ? 434 : 61;
         c1 = (m == 0) ? -2291 : -371;
         c2 = (m == 0) ? 26984 : 25699;
         run_block(6, 16'h4000);
      end
      $display("test defaults done");
   endtask

   task automatic t_custom();
      // Custom set at 64x, kept below the power of the 64x default set
      setup(8'h42);
      c0 = -200;
      c1 = 4660;
      c2 = -24000;
      run_block(7, 16'h4000);
      reg_write(8'h14, 8'h00);
      c2 = -24064;
      run_block(5, 16'h2000);
      $display("test custom done");
   endtask

   task automatic t_fill();
      int cnt;
      // Five taps of 11000 stay within the power limit yet clip a full-scale input
      for (int i = 0; i < 6; i++) reg_write(8'(8'h10 + i), (i % 2) ? 8'h2A : 8'hF8);
      c0 = 11000;
      c1 = 11000;
      c2 = 11000;
      cnt = 0;
      in_valid = 1'b1;
      in_left = 16'h7FFF;
      in_right = 16'h8000;
      for (int i = 0; i < 20; i++) begin
         if (in_ready === 1'b1) begin
            model_push(16'h7FFF, 16'h8000);
            cnt++;
         end
         @(posedge ref_clk);
         #1;
      end
      in_valid = 1'b0;
      chk({15'h0000, in_ready}, 16'h0000);
      chk(16'((cnt >= 8 && cnt <= 10) ? 1 : 0), 16'h0001);
      recv_all();
      repeat (3) @(posedge ref_clk);
      #1 chk({15'h0000, out_valid}, 16'h0000);
      chk({15'h0000, in_ready}, 16'h0001);
      $display("test fill and drain done");
   endtask

   // Lone impulse on the inner taps: the negative default must show as a negative output
   task automatic t_signs();
      logic [15:0] v;
      setup(8'h00);
      c0 = 434;
      c1 = -2291;
      c2 = 26984;
      for (int k = 0; k < 7; k++) begin
         v = (k == 3) ? 16'h0100 : 16'h0000;
         send(v, v);
      end
      in_valid = 1'b0;
      recv_all();
      $display("test signs done");
   endtask

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      in_valid = 1'b0;
      in_left = 16'h0000;
      in_right = 16'h0000;
      out_ready = 1'b0;
      c0 = 0;
      c1 = 0;
      c2 = 0;
      foreach (hl[i]) begin
         hl[i] = 0;
         hr[i] = 0;
      end
      repeat (3) @(posedge ref_clk);
      #1 resetn = 1'b1;
      @(posedge ref_clk);
      #1;
      t_reset();
      t_regs();
      t_defaults();
      t_custom();
      t_fill();
      t_signs();
      complete_run();
   end
endmodule
`default_nettype wire
